// ===== hdl/pwm_steer_params.svh
`ifndef PWM_STEER_PARAMS_SVH
`define PWM_STEER_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_OUT_CTRL 8'h00
`define OFS_TRIG_CMP 8'h04
`define OFS_TRG_SEL 8'h08
`define OFS_FLT_CTRL 8'h0c
`define OFS_PWM_CTRL 8'h10
`define OFS_PERIOD 8'h14
`define OFS_DUTY 8'h18
`define OFS_SW_TRIG 8'h1c
`define OFS_STATUS 8'h20

// ****************************************
// field positions and write masks
// ****************************************
`define B_ALIGN 0
`define B_SWAP 1
`define B_LIM_STATE_L 2
`define B_LIM_STATE_H 3
`define B_POL_L 4
`define B_POL_H 5
`define B_OVR_VAL_L 8
`define B_OVR_VAL_H 9
`define B_OVR_EN_L 10
`define B_OVR_EN_H 11
`define B_LIM_EN 0
`define B_INDEP 15
`define B_ENABLE 15
`define B_SW_COMMON 0
`define B_SW_LEVEL 1
`define TRG_LSB 3
`define M_OUT_CTRL 16'h0f3f
`define M_TRIG_CMP 16'hfff8
`define M_TRG_SEL 16'h1f1f
`define M_FLT_CTRL 16'h8001
`define M_PWM_CTRL 16'h8000

// ****************************************
// reset values
// ****************************************
`define RST_REG16 16'h0000
`define RST_CNT13 13'h0000

// ****************************************
// trigger source codes
// ****************************************
`define TRG_SW_COMMON 5'h01
`define TRG_SW_LEVEL 5'h02
`define TRG_SPECIAL 5'h04
`define TRG_PRIM_G1 5'h05
`define TRG_PRIM_G5 5'h09
`define TRG_TMR1 5'h0c
`define TRG_TMR2 5'h0d
`define TRG_SEC_SPECIAL 5'h0e
`define TRG_SEC_G1 5'h0f
`define TRG_SEC_G5 5'h13
`define TRG_OC1 5'h16
`define TRG_OC2 5'h17
`define TRG_LIM_G1 5'h18
`define TRG_LIM_G5 5'h1c
`define TRG_EXT 5'h1f

`endif

// ===== hdl/pwm_steer_pkg.sv
package pwm_steer_pkg;

	// ****************************************
	// bus data phase
	// ****************************************
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_WRITE = 2'b01,
		PH_READ = 2'b11
	} phase_t;

	// ****************************************
	// whole block state
	// ****************************************
	typedef struct packed {
		phase_t phase;
		logic [7:0] addr;
		logic [31:0] rdata;
		logic ready;
		logic resp;
		logic [15:0] out_ctrl;
		logic [15:0] trig_cmp;
		logic [15:0] trg_sel;
		logic [15:0] flt_ctrl;
		logic [15:0] pwm_ctrl;
		logic [12:0] period;
		logic [12:0] duty;
		logic sw_level;
		logic sw_common;
		logic [12:0] tb_cnt;
		logic [3:0] ovr;
		logic lim_s1;
		logic lim_s2;
		logic ext_s1;
		logic ext_s2;
		logic prev_a;
		logic prev_b;
		logic trig_a;
		logic trig_b;
		logic prim_trig;
		logic out_h;
		logic out_l;
	} state_t;

endpackage

// ===== hdl/pwm_output_steer_and_adc_trigger.sv
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "pwm_steer_params.svh"

module pwm_output_steer_and_adc_trigger (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic current_limit_pin,
	input wire logic external_trigger_pin,
	input wire logic special_evt,
	input wire logic sec_special_evt,
	input wire logic [4:0] prim_trig_in,
	input wire logic [4:0] sec_trig_in,
	input wire logic [4:0] limit_trig_in,
	input wire logic timer1_match,
	input wire logic timer2_match,
	input wire logic oc1_evt,
	input wire logic oc2_evt,
	output logic high_side_output,
	output logic low_side_output,
	output logic primary_trigger,
	output logic conv_trigger_a,
	output logic conv_trigger_b
);
	import pwm_steer_pkg::*;

	state_t s_q;
	state_t s_d;

	logic take;
	logic enabled;
	logic wrap;
	logic gen_h;
	logic gen_l;
	logic sw_h;
	logic sw_l;
	logic act_h;
	logic act_l;
	logic lim_on;
	logic raw_a;
	logic raw_b;
	logic [31:0] ev;
	logic [3:0] ovr_req;
	logic [15:0] wd;

	// ****************************************
	// register read mux
	// ****************************************
	function automatic logic [31:0] rd_mux(
		input state_t n,
		input logic [7:0] a
	);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (a == `OFS_OUT_CTRL) begin
			r[15:0] = n.out_ctrl;
		end else if (a == `OFS_TRIG_CMP) begin
			r[15:0] = n.trig_cmp;
		end else if (a == `OFS_TRG_SEL) begin
			r[15:0] = n.trg_sel;
		end else if (a == `OFS_FLT_CTRL) begin
			r[15:0] = n.flt_ctrl;
		end else if (a == `OFS_PWM_CTRL) begin
			r[15:0] = n.pwm_ctrl;
		end else if (a == `OFS_PERIOD) begin
			r[12:0] = n.period;
		end else if (a == `OFS_DUTY) begin
			r[12:0] = n.duty;
		end else if (a == `OFS_SW_TRIG) begin
			r[`B_SW_LEVEL] = n.sw_level;
		end else if (a == `OFS_STATUS) begin
			r[12:0] = n.tb_cnt;
			r[13] = n.lim_s2;
			r[14] = n.out_l;
			r[15] = n.out_h;
		end
		return r;
	endfunction

	// ****************************************
	// trigger event vector
	// ****************************************
	always_comb begin
		ev = 32'h0000_0000;
		ev[`TRG_SW_COMMON] = s_q.sw_common;
		ev[`TRG_SW_LEVEL] = s_q.sw_level;
		ev[`TRG_SPECIAL] = special_evt;
		ev[`TRG_PRIM_G5:`TRG_PRIM_G1] = prim_trig_in;
		ev[`TRG_TMR1] = timer1_match;
		ev[`TRG_TMR2] = timer2_match;
		ev[`TRG_SEC_SPECIAL] = sec_special_evt;
		ev[`TRG_SEC_G5:`TRG_SEC_G1] = sec_trig_in;
		ev[`TRG_OC1] = oc1_evt;
		ev[`TRG_OC2] = oc2_evt;
		ev[`TRG_LIM_G5:`TRG_LIM_G1] = limit_trig_in;
		ev[`TRG_EXT] = s_q.ext_s2;
	end

	assign raw_a = ev[s_q.trg_sel[4:0]];
	assign raw_b = ev[s_q.trg_sel[12:8]];

	// ****************************************
	// output path
	// ****************************************
	assign enabled = s_q.pwm_ctrl[`B_ENABLE];
	assign wrap = (s_q.tb_cnt == s_q.period);
	assign gen_h = enabled && (s_q.tb_cnt < s_q.duty);
	assign gen_l = enabled && !gen_h;
	assign ovr_req = {
		s_q.out_ctrl[`B_OVR_EN_H],
		s_q.out_ctrl[`B_OVR_EN_L],
		s_q.out_ctrl[`B_OVR_VAL_H],
		s_q.out_ctrl[`B_OVR_VAL_L]
	};
	assign lim_on = s_q.flt_ctrl[`B_LIM_EN] && s_q.lim_s2;

	always_comb begin
		if (s_q.out_ctrl[`B_SWAP]) begin
			sw_h = gen_l;
			sw_l = gen_h;
		end else begin
			sw_h = gen_h;
			sw_l = gen_l;
		end
		act_h = s_q.ovr[3] ? s_q.ovr[1] : sw_h;
		act_l = s_q.ovr[2] ? s_q.ovr[0] : sw_l;
		// idle module drives inactive, but a live limit still wins
		if (!enabled) begin
			act_h = 1'b0;
			act_l = 1'b0;
		end
		if (lim_on) begin
			if (!s_q.flt_ctrl[`B_INDEP]) begin
				act_h = s_q.out_ctrl[`B_LIM_STATE_H];
				act_l = s_q.out_ctrl[`B_LIM_STATE_L];
			end else begin
				act_h = 1'b0;
				act_l = 1'b0;
			end
		end
	end

	// ****************************************
	// next state
	// ****************************************
	assign take = hsel && htrans[1] && hready;
	assign wd = hwdata[15:0];

	always_comb begin
		s_d = s_q;
		s_d.sw_common = 1'b0;
		s_d.ready = 1'b1;
		s_d.resp = 1'b0;
		// data phase write
		if (s_q.phase == PH_WRITE) begin
			if (s_q.addr == `OFS_OUT_CTRL) begin
				s_d.out_ctrl = wd & `M_OUT_CTRL;
			end else if (s_q.addr == `OFS_TRIG_CMP) begin
				s_d.trig_cmp = wd & `M_TRIG_CMP;
			end else if (s_q.addr == `OFS_TRG_SEL) begin
				s_d.trg_sel = wd & `M_TRG_SEL;
			end else if (s_q.addr == `OFS_FLT_CTRL) begin
				s_d.flt_ctrl = wd & `M_FLT_CTRL;
			end else if (s_q.addr == `OFS_PWM_CTRL) begin
				s_d.pwm_ctrl = wd & `M_PWM_CTRL;
			end else if (s_q.addr == `OFS_PERIOD) begin
				s_d.period = wd[12:0];
			end else if (s_q.addr == `OFS_DUTY) begin
				s_d.duty = wd[12:0];
			end else if (s_q.addr == `OFS_SW_TRIG) begin
				s_d.sw_common = wd[`B_SW_COMMON];
				s_d.sw_level = wd[`B_SW_LEVEL];
			end
		end
		// address phase
		s_d.phase = PH_IDLE;
		if (take) begin
			s_d.addr = haddr[7:0];
			if (hwrite) begin
				s_d.phase = PH_WRITE;
			end else begin
				s_d.phase = PH_READ;
			end
		end
		// time base
		if (!enabled) begin
			s_d.tb_cnt = `RST_CNT13;
		end else if (wrap) begin
			s_d.tb_cnt = `RST_CNT13;
		end else begin
			s_d.tb_cnt = s_q.tb_cnt + 13'h0001;
		end
		// override application
		if (s_q.out_ctrl[`B_ALIGN]) begin
			if (wrap || !enabled) begin
				s_d.ovr = ovr_req;
			end
		end else begin
			s_d.ovr = ovr_req;
		end
		// pin synchronisers
		s_d.lim_s1 = current_limit_pin;
		s_d.lim_s2 = s_q.lim_s1;
		s_d.ext_s1 = external_trigger_pin;
		s_d.ext_s2 = s_q.ext_s1;
		// primary trigger on compare match
		s_d.prim_trig = enabled && (s_q.tb_cnt == s_q.trig_cmp[15:`TRG_LSB]);
		// converter trigger pulses
		s_d.prev_a = raw_a;
		s_d.prev_b = raw_b;
		if (s_q.trg_sel[4:0] == `TRG_SW_LEVEL) begin
			s_d.trig_a = raw_a;
		end else begin
			s_d.trig_a = raw_a && !s_q.prev_a;
		end
		if (s_q.trg_sel[12:8] == `TRG_SW_LEVEL) begin
			s_d.trig_b = raw_b;
		end else begin
			s_d.trig_b = raw_b && !s_q.prev_b;
		end
		// pin levels through polarity
		s_d.out_h = act_h ^ s_q.out_ctrl[`B_POL_H];
		s_d.out_l = act_l ^ s_q.out_ctrl[`B_POL_L];
		// read data from the updated image
		if (take && !hwrite) begin
			s_d.rdata = rd_mux(s_d, haddr[7:0]);
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q.phase <= PH_IDLE;
			s_q.addr <= 8'h00;
			s_q.rdata <= 32'h0000_0000;
			s_q.ready <= 1'b1;
			s_q.resp <= 1'b0;
			s_q.out_ctrl <= `RST_REG16;
			s_q.trig_cmp <= `RST_REG16;
			s_q.trg_sel <= `RST_REG16;
			s_q.flt_ctrl <= `RST_REG16;
			s_q.pwm_ctrl <= `RST_REG16;
			s_q.period <= `RST_CNT13;
			s_q.duty <= `RST_CNT13;
			s_q.sw_level <= 1'b0;
			s_q.sw_common <= 1'b0;
			s_q.tb_cnt <= `RST_CNT13;
			s_q.ovr <= 4'h0;
			s_q.lim_s1 <= 1'b0;
			s_q.lim_s2 <= 1'b0;
			s_q.ext_s1 <= 1'b0;
			s_q.ext_s2 <= 1'b0;
			s_q.prev_a <= 1'b0;
			s_q.prev_b <= 1'b0;
			s_q.trig_a <= 1'b0;
			s_q.trig_b <= 1'b0;
			s_q.prim_trig <= 1'b0;
			s_q.out_h <= 1'b0;
			s_q.out_l <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign hreadyout = s_q.ready;
	assign hrdata = s_q.rdata;
	assign hresp = s_q.resp;
	assign high_side_output = s_q.out_h;
	assign low_side_output = s_q.out_l;
	assign primary_trigger = s_q.prim_trig;
	assign conv_trigger_a = s_q.trig_a;
	assign conv_trigger_b = s_q.trig_b;

endmodule

// ===== sim/steer_sva.sv
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module steer_sva (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic current_limit_pin,
	input wire logic external_trigger_pin,
	input wire logic high_side_output,
	input wire logic low_side_output,
	input wire logic conv_trigger_a
);
	logic wv_q, rv_q, tk, pe_q;
	logic [7:0] a_q;
	logic [15:0] oc_q, fc_q, ts_q;
	logic [3:0] q_q;
	assign tk = hsel && htrans[1] && hready;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wv_q <= 1'b0;
			rv_q <= 1'b0;
			a_q <= 8'h00;
			oc_q <= 16'h0000;
			fc_q <= 16'h0000;
			ts_q <= 16'h0000;
			q_q <= 4'h0;
			pe_q <= 1'b0;
		end else begin
			if (wv_q && a_q == 8'h10) begin
				pe_q <= hwdata[15];
			end
			wv_q <= tk && hwrite;
			rv_q <= tk && !hwrite;
			if (tk) begin
				a_q <= haddr[7:0];
			end
			q_q <= wv_q ? 4'h0 : q_q + {3'h0, q_q != 4'hf};
			if (wv_q && a_q == 8'h00) begin
				oc_q <= hwdata[15:0];
			end
			if (wv_q && a_q == 8'h0c) begin
				fc_q <= hwdata[15:0];
			end
			if (wv_q && a_q == 8'h08) begin
				ts_q <= hwdata[15:0];
			end
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_lim_high: assert property (
		(current_limit_pin [*5]) ##0 (q_q > 4'h3 && fc_q[0] && !fc_q[15])
		|-> high_side_output == (oc_q[3] ^ oc_q[5])) else $error("limit high pin wrong");
	a_lim_low: assert property (
		(current_limit_pin [*5]) ##0 (q_q > 4'h3 && fc_q[0] && !fc_q[15])
		|-> low_side_output == (oc_q[2] ^ oc_q[4])) else $error("limit low pin wrong");
	a_indep_mode: assert property (
		(current_limit_pin [*5]) ##0 (q_q > 4'h3 && fc_q[0] && fc_q[15])
		|-> high_side_output == oc_q[5] && low_side_output == oc_q[4]) else $error("limit state not ignored");
	a_ovr_low: assert property (
		q_q > 4'h3 && pe_q && !fc_q[0] && oc_q[10] && !oc_q[0]
		|-> low_side_output == (oc_q[8] ^ oc_q[4])) else $error("override low pin wrong");
	a_rsv_zero: assert property (
		rv_q && a_q == 8'h04 |-> hrdata[2:0] == 3'h0) else $error("compare low bits not zero");
	a_sel_off: assert property (
		ts_q[4:0] == 5'h00 && $past(ts_q[4:0]) == 5'h00 |-> !conv_trigger_a) else $error("trigger while off");
	a_one_pulse: assert property (
		conv_trigger_a && ts_q[4:0] != 5'h02 && $past(ts_q[4:0]) != 5'h02
		|=> !conv_trigger_a) else $error("trigger pulse too long");
	a_ext_pin: assert property (
		q_q > 4'h3 && ts_q[4:0] == 5'h1f && $rose(external_trigger_pin)
		|-> ##[2:4] conv_trigger_a) else $error("external pin trigger missing");
	c_trig: cover property (conv_trigger_a);
	c_lim: cover property (fc_q[0] && current_limit_pin);
	c_cmp_read: cover property (rv_q && a_q == 8'h04);
endmodule
bind pwm_output_steer_and_adc_trigger steer_sva steer_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hwdata, .hrdata, .current_limit_pin, .external_trigger_pin, .high_side_output, .low_side_output,
	.conv_trigger_a);

// ===== sim/conv_side_model.sv
`timescale 1ns/1ps
// ****************************************
// event sources and converter tally
// ****************************************
module conv_side_model (
	input wire logic hclk,
	input wire logic clr,
	input wire logic [31:0] ev,
	input wire logic conv_trigger_a,
	input wire logic conv_trigger_b,
	output logic special_evt,
	output logic sec_special_evt,
	output logic [4:0] prim_trig_in,
	output logic [4:0] sec_trig_in,
	output logic [4:0] limit_trig_in,
	output logic timer1_match,
	output logic timer2_match,
	output logic oc1_evt,
	output logic oc2_evt,
	output logic external_trigger_pin,
	output logic [7:0] cnt_a_q,
	output logic [7:0] cnt_b_q
);
	assign special_evt = ev[4];
	assign prim_trig_in = ev[9:5];
	assign timer1_match = ev[12];
	assign timer2_match = ev[13];
	assign sec_special_evt = ev[14];
	assign sec_trig_in = ev[19:15];
	assign oc1_evt = ev[22];
	assign oc2_evt = ev[23];
	assign limit_trig_in = ev[28:24];
	assign external_trigger_pin = ev[31];
	always_ff @(posedge hclk) begin
		cnt_a_q <= clr ? 8'h00 : cnt_a_q + {7'h0, conv_trigger_a};
		cnt_b_q <= clr ? 8'h00 : cnt_b_q + {7'h0, conv_trigger_b};
	end
endmodule

// ===== sim/pwm_output_steer_and_adc_trigger_bench.sv
`timescale 1ns/1ps
// ****************************************
// register and pin tests
// ****************************************
module pwm_output_steer_and_adc_trigger_bench;
	logic hclk, hresetn, hsel, hwrite, current_limit_pin, clr, hreadyout, hresp, primary_trigger;
	logic high_side_output, low_side_output, conv_trigger_a, conv_trigger_b, special_evt, sec_special_evt;
	logic timer1_match, timer2_match, oc1_evt, oc2_evt, external_trigger_pin;
	logic [1:0] htrans;
	logic [4:0] prim_trig_in, sec_trig_in, limit_trig_in;
	logic [7:0] cnt_a_q, cnt_b_q;
	logic [31:0] haddr, hwdata, hrdata, ev, rd;
	logic [31:0] valid_m = 32'h9fcff3f6;
	int miscompares, n_checks, n;
	pwm_output_steer_and_adc_trigger pwm_output_steer_and_adc_trigger_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .current_limit_pin,
		.external_trigger_pin, .special_evt, .sec_special_evt, .prim_trig_in, .sec_trig_in, .limit_trig_in,
		.timer1_match, .timer2_match, .oc1_evt, .oc2_evt, .high_side_output, .low_side_output, .primary_trigger,
		.conv_trigger_a, .conv_trigger_b);
	conv_side_model conv_side_model_i (.hclk, .clr, .ev, .conv_trigger_a, .conv_trigger_b, .special_evt,
		.sec_special_evt, .prim_trig_in, .sec_trig_in, .limit_trig_in, .timer1_match, .timer2_match, .oc1_evt,
		.oc2_evt, .external_trigger_pin, .cnt_a_q, .cnt_b_q);
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wait_rdy();
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			give_verdict();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= {16'h0, d};
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic pins(input logic [1:0] e);
		chk("pins", {30'h0, e}, {30'h0, high_side_output, low_side_output});
	endtask
	task automatic wait_prim();
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (primary_trigger !== 1'b1 && n < 40);
	endtask
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		{hresetn, hsel, hwrite, current_limit_pin, htrans, haddr, hwdata, ev} = '0;
		clr = 1'b1;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 8'h04, 16'h0);
		chk("trig_cmp", 32'h0, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
		bus(1'b1, 8'h3c, 16'hffff);
		bus(1'b0, 8'h3c, 16'h0);
		chk("unmapped", 32'h0, rd);
		bus(1'b1, 8'h04, 16'hffff);
		bus(1'b0, 8'h04, 16'h0);
		chk("trig_cmp", 32'hfff8, rd);
		$display("test registers done");
		bus(1'b1, 8'h0c, 16'h0001);
		current_limit_pin <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 8'h00, 16'(48 + 4 * i));
			repeat (6) @(posedge hclk);
			pins({~i[1], ~i[0]});
		end
		bus(1'b1, 8'h0c, 16'h8001);
		repeat (6) @(posedge hclk);
		pins(2'b11);
		current_limit_pin <= 1'b0;
		bus(1'b1, 8'h0c, 16'h0);
		bus(1'b1, 8'h00, 16'h0);
		$display("test current_limit done");
		bus(1'b1, 8'h14, 16'h0009);
		bus(1'b1, 8'h04, 16'h0028);
		bus(1'b1, 8'h18, 16'h1fff);
		bus(1'b1, 8'h10, 16'h8000);
		wait_prim();
		wait_prim();
		chk("trig_period", 32'd10, n);
		bus(1'b1, 8'h04, 16'h0100);
		wait_prim();
		chk("trig_none", 32'd40, n);
		pins(2'b10);
		bus(1'b1, 8'h00, 16'h0002);
		repeat (4) @(posedge hclk);
		pins(2'b01);
		$display("test time_base done");
		bus(1'b1, 8'h00, 16'h0);
		bus(1'b1, 8'h14, 16'h0040);
		bus(1'b1, 8'h04, 16'h0);
		wait_prim();
		bus(1'b1, 8'h00, 16'h0801);
		repeat (3) @(posedge hclk);
		pins(2'b10);
		repeat (70) @(posedge hclk);
		pins(2'b00);
		wait_prim();
		bus(1'b1, 8'h00, 16'h0500);
		repeat (3) @(posedge hclk);
		pins(2'b11);
		bus(1'b1, 8'h10, 16'h0);
		$display("test override done");
		for (int c = 0; c < 32; c++) begin
			bus(1'b1, 8'h08, 16'(c * 257));
			repeat (4) @(posedge hclk);
			for (int s = 0; s < 32; s++) begin
				clr <= 1'b1;
				@(posedge hclk);
				clr <= 1'b0;
				if (s == 1 || s == 2) begin
					bus(1'b1, 8'h1c, 16'(s));
				end else begin
					ev <= 32'h1 << s;
				end
				@(posedge hclk);
				ev <= 32'h0;
				if (s == 2) begin
					bus(1'b1, 8'h1c, 16'h0);
				end
				repeat (6) @(posedge hclk);
				chk("trig_a", {31'h0, c == s && valid_m[s]}, {31'h0, cnt_a_q != 8'h0});
				chk("trig_b", {31'h0, c == s && valid_m[s]}, {31'h0, cnt_b_q != 8'h0});
			end
		end
		$display("test trigger_select done");
		give_verdict();
	end
endmodule
